/* rtl/pat_top.sv */
// Purpose : agent temperature poller with AXI4-Lite registers
// Assumes : link engine on CLK runs one transaction per request
// Notes   : result bytes show the last reported agent value
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pat_cfg.svh"
// Overview of operation
// - each agent has a 7-bit reference value, bit 7 reads zero.
// - bits 7..4 of the domain register flag a second domain per agent.
// - with return-highest set, the larger of both domains is reported.
// - bit 0 hands the bus to an external host and silences ours.
// - an agent's alert flag rises after three failed transactions.
// - the speed code picks 1.5 MHz, 750 kHz, 375 kHz or 187.5 kHz.
// - the 8-bit target address register resets to 48h.
// - the high result byte is read-only.
// - the low result byte is read-only.
// - both result bytes form one 16-bit two's-complement value.
// - only agents whose enable bit is set are addressed.
// - the domain select bit counts only with a second domain present.
// - agents 1 to 4 use client addresses 30h to 33h.
module pat_top #(
  parameter int AW = 12
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic [AW-1:0]     S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output var  logic              S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output var  logic              S_AXI_WREADY,
  output var  logic [1:0]        S_AXI_BRESP,
  output var  logic              S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [AW-1:0]     S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output var  logic              S_AXI_ARREADY,
  output var  logic [31:0]       S_AXI_RDATA,
  output var  logic [1:0]        S_AXI_RRESP,
  output var  logic              S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output var  logic              PECI_REQ,
  output var  pat_pkg::pat_byte_type PECI_ADDR,
  output var  logic              PECI_DOMAIN,
  output var  logic              PECI_BIT_TICK,
  input  wire logic              PECI_DONE,
  input  wire logic              PECI_ACK,
  input  wire pat_pkg::pat_temp_type PECI_DATA,
  output var  logic              HOST_OWNS_BUS,
  output var  logic              IRQ
);
  import pat_pkg::*;
  // ========================================================
  // state and helpers
  pat_core_type r_q;
  pat_core_type r_d;
  logic         aw_hs;
  logic         w_hs;
  logic         ar_hs;
  logic         wr_go;
  logic         ext_host;
  logic         ret_high;
  logic [3:0]   en_vec;
  logic [3:0]   d1_vec;
  logic [3:0]   sel_vec;
  logic         two_now;
  logic         dom_now;
  logic         done_ok;
  logic         done_bad;
  logic         upd;
  logic [1:0]   fail_inc;
  logic [3:0]   alert_rise;
  logic [4:0]   irq_clr;
  pat_temp_type new_temp;
  logic         ar_ok;
  logic         ar_hit;
  pat_byte_type ar_val;
  logic         aw_hit;

  function automatic logic reg_hit(input pat_byte_type idx);
    case (idx)
      `PAT_IDX_AGENT_CFG, `PAT_IDX_TBASE1, `PAT_IDX_TBASE2,
      `PAT_IDX_TBASE3, `PAT_IDX_TBASE4, `PAT_IDX_DOM_HOST,
      `PAT_IDX_WARN, `PAT_IDX_SST, `PAT_IDX_IRQ_STAT,
      `PAT_IDX_IRQ_MASK, `PAT_IDX_TEMP_HI,
      `PAT_IDX_TEMP_LO: reg_hit = 1'b1;
      default:          reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  function automatic pat_byte_type reg_val(input pat_byte_type idx,
                                           input pat_core_type r);
    case (idx)
      `PAT_IDX_AGENT_CFG: reg_val = r.agent_cfg;
      `PAT_IDX_TBASE1:    reg_val = {1'b0, r.temperature_reference_value[0]};
      `PAT_IDX_TBASE2:    reg_val = {1'b0, r.temperature_reference_value[1]};
      `PAT_IDX_TBASE3:    reg_val = {1'b0, r.temperature_reference_value[2]};
      `PAT_IDX_TBASE4:    reg_val = {1'b0, r.temperature_reference_value[3]};
      `PAT_IDX_DOM_HOST:  reg_val = r.dom_host;
      `PAT_IDX_WARN:      reg_val = {r.absent, 2'h0, r.speed};
      `PAT_IDX_SST:       reg_val = r.sst;
      `PAT_IDX_IRQ_STAT:  reg_val = {3'h0, r.irq_stat};
      `PAT_IDX_IRQ_MASK:  reg_val = {3'h0, r.irq_mask};
      `PAT_IDX_TEMP_HI:   reg_val = r.temp[15:8];
      `PAT_IDX_TEMP_LO:   reg_val = r.temp[7:0];
      default:            reg_val = 8'h00;
    endcase
  endfunction : reg_val

  assign aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs     = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
  assign wr_go    = r_q.aw_full & r_q.w_full & ~r_q.bvalid;
  assign aw_hit   = r_q.aw_ok & reg_hit(r_q.aw_idx);
  assign ar_ok    = S_AXI_ARADDR[AW-1:`PAT_IDX_HI+1] == '0;
  assign ar_hit   = ar_ok &
                    reg_hit(S_AXI_ARADDR[`PAT_IDX_HI:`PAT_IDX_LO]);
  assign ar_val   = reg_val(S_AXI_ARADDR[`PAT_IDX_HI:`PAT_IDX_LO], r_q);
  assign ext_host = r_q.dom_host[`PAT_BIT_EXT_HOST];
  assign ret_high = r_q.dom_host[`PAT_BIT_RET_HIGH];
  assign en_vec   = r_q.agent_cfg[7:4];
  assign sel_vec  = r_q.agent_cfg[3:0];
  assign d1_vec   = r_q.dom_host[7:4];
  assign two_now  = ret_high & d1_vec[r_q.agent];
  // select only counts with a second domain
  assign dom_now  = d1_vec[r_q.agent] & sel_vec[r_q.agent];
  assign done_ok  = (r_q.state == PAT_REQ) & PECI_DONE & PECI_ACK;
  assign done_bad = (r_q.state == PAT_REQ) & PECI_DONE & ~PECI_ACK;
  assign upd      = done_ok & ~(r_q.two_pass & ~r_q.second);
  // signed compare keeps values below zero in order
  assign new_temp = (r_q.two_pass &&
                     $signed(r_q.d0) > $signed(PECI_DATA)) ?
                    r_q.d0 : PECI_DATA;
  assign fail_inc = (r_q.fails[r_q.agent] == `PAT_ALERT_FAILS) ?
                    `PAT_ALERT_FAILS :
                    2'(r_q.fails[r_q.agent] + 2'h1);
  assign irq_clr  = (wr_go && aw_hit && r_q.w_be &&
                     r_q.aw_idx == `PAT_IDX_IRQ_STAT) ?
                    r_q.w_data[4:0] : 5'h0;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_alert
      assign alert_rise[g] = done_bad && r_q.agent == 2'(g) &&
                             fail_inc == `PAT_ALERT_FAILS &&
                             !r_q.absent[g];
    end
  endgenerate

  // ========================================================
  // next state
  always_comb begin
    r_d = r_q;
    // write address and data may arrive in either order
    if (aw_hs) begin
      r_d.aw_full = 1'b1;
      r_d.aw_idx  = S_AXI_AWADDR[`PAT_IDX_HI:`PAT_IDX_LO];
      r_d.aw_ok   = S_AXI_AWADDR[AW-1:`PAT_IDX_HI+1] == '0;
    end
    if (w_hs) begin
      r_d.w_full = 1'b1;
      r_d.w_data = S_AXI_WDATA[7:0];
      r_d.w_be   = S_AXI_WSTRB[0];
    end
    if (r_q.bvalid && S_AXI_BREADY) begin
      r_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      r_d.aw_full = 1'b0;
      r_d.w_full  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = aw_hit ? `PAT_RESP_OKAY : `PAT_RESP_SLVERR;
      if (aw_hit && r_q.w_be) begin
        case (r_q.aw_idx)
          `PAT_IDX_AGENT_CFG: r_d.agent_cfg = r_q.w_data;
          `PAT_IDX_TBASE1,
          `PAT_IDX_TBASE2,
          `PAT_IDX_TBASE3,
          `PAT_IDX_TBASE4: begin
            r_d.temperature_reference_value[2'(r_q.aw_idx - `PAT_IDX_TBASE1)] =
              r_q.w_data[6:0];
          end
          `PAT_IDX_DOM_HOST: begin
            r_d.dom_host = r_q.w_data & `PAT_DOM_HOST_MASK;
          end
          `PAT_IDX_WARN:     r_d.speed = r_q.w_data[1:0];
          `PAT_IDX_SST:      r_d.sst = r_q.w_data;
          `PAT_IDX_IRQ_MASK: r_d.irq_mask = r_q.w_data[4:0];
          // result bytes ignore writes
          default: ;
        endcase
      end
    end
    if (ar_hs) begin
      r_d.rvalid = 1'b1;
      r_d.rdata  = ar_val;
      r_d.rresp  = ar_hit ? `PAT_RESP_OKAY : `PAT_RESP_SLVERR;
    end else if (r_q.rvalid && S_AXI_RREADY) begin
      r_d.rvalid = 1'b0;
    end
    // poller
    unique case (r_q.state)
      PAT_IDLE: begin
        // a transaction already begun is finished before handing over
        if (!ext_host) begin
          if (en_vec[r_q.agent]) begin
            r_d.state    = PAT_REQ;
            r_d.req      = 1'b1;
            r_d.two_pass = two_now;
            r_d.second   = 1'b0;
            r_d.domain   = two_now ? 1'b0 : dom_now;
            r_d.addr     = 8'(`PAT_AGENT_BASE + r_q.agent);
          end else begin
            r_d.agent = 2'(r_q.agent + 2'h1);
          end
        end
      end
      PAT_REQ: begin
        if (PECI_DONE) begin
          r_d.req = 1'b0;
          if (PECI_ACK) begin
            r_d.fails[r_q.agent]  = 2'h0;
            r_d.absent[r_q.agent] = 1'b0;
            if (r_q.two_pass && !r_q.second) begin
              r_d.d0     = PECI_DATA;
              r_d.second = 1'b1;
              r_d.domain = 1'b1;
              r_d.state  = PAT_GAP;
            end else begin
              r_d.temp  = new_temp;
              r_d.state = PAT_IDLE;
              r_d.agent = 2'(r_q.agent + 2'h1);
            end
          end else begin
            r_d.fails[r_q.agent] = fail_inc;
            if (fail_inc == `PAT_ALERT_FAILS) begin
              r_d.absent[r_q.agent] = 1'b1;
            end
            r_d.state = PAT_IDLE;
            r_d.agent = 2'(r_q.agent + 2'h1);
          end
        end
      end
      PAT_GAP: begin
        // one idle cycle separates the two domain reads
        r_d.req   = 1'b1;
        r_d.state = PAT_REQ;
      end
    endcase
    // set wins over a clear in the same cycle
    r_d.irq_stat = (r_q.irq_stat & ~irq_clr) | {upd, alert_rise};
    r_d.irq      = |(r_d.irq_stat & r_d.irq_mask);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_q       <= '0;
      r_q.state <= PAT_IDLE;
      r_q.temperature_reference_value <= {4{`PAT_TEMPERATURE_REFERENCE_VALUE_RST}};
      r_q.sst   <= `PAT_SST_RST;
    end else begin
      r_q <= r_d;
    end
  end

  pat_rate_gen u_rate (
    .clk    (CLK),
    .resetn (RESETN),
    .speed  (r_q.speed),
    .tick   (PECI_BIT_TICK)
  );

  // ========================================================
  // outputs
  assign S_AXI_AWREADY = ~r_q.aw_full & ~r_q.bvalid;
  assign S_AXI_WREADY  = ~r_q.w_full & ~r_q.bvalid;
  assign S_AXI_BVALID  = r_q.bvalid;
  assign S_AXI_BRESP   = r_q.bresp;
  assign S_AXI_ARREADY = ~r_q.rvalid;
  assign S_AXI_RVALID  = r_q.rvalid;
  assign S_AXI_RRESP   = r_q.rresp;
  assign S_AXI_RDATA   = {24'h0, r_q.rdata};
  assign PECI_REQ      = r_q.req;
  assign PECI_ADDR     = r_q.addr;
  assign PECI_DOMAIN   = r_q.domain;
  assign HOST_OWNS_BUS = ~ext_host;
  assign IRQ           = r_q.irq;

  // ========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_temperature_reference_value_write: assert property (
    wr_go && aw_hit && r_q.w_be && r_q.aw_idx == `PAT_IDX_TBASE4
    |=> r_q.temperature_reference_value[3] == $past(r_q.w_data[6:0]))
    else $error("reference value not stored");
  a_domain_sel: assert property (
    $rose(PECI_REQ) && !r_q.two_pass
    |-> PECI_DOMAIN == $past(dom_now))
    else $error("wrong domain requested");
  a_highest_pick: assert property (
    upd && r_q.two_pass
    |=> $signed(r_q.temp) >= $signed($past(r_q.d0)))
    else $error("highest domain not reported");
  a_ext_quiet: assert property (
    ext_host && r_q.state == PAT_IDLE |=> !PECI_REQ)
    else $error("internal host drove while external owns bus");
  a_alert_three: assert property (
    done_bad && r_q.fails[r_q.agent] == 2'h2
    |=> r_q.absent[$past(r_q.agent)])
    else $error("alert not raised on third failure");
  a_alert_clear: assert property (
    done_ok |=> !r_q.absent[$past(r_q.agent)])
    else $error("alert kept after a good transaction");
  a_sst_reset: assert property (
    $rose(RESETN) |-> r_q.sst == `PAT_SST_RST)
    else $error("target address reset value wrong");
  a_result_hold: assert property (
    !upd |=> $stable(r_q.temp))
    else $error("result changed without a transaction");
  a_only_enabled: assert property (
    $rose(PECI_REQ) && !r_q.second |-> $past(en_vec[r_q.agent]))
    else $error("disabled agent addressed");
  a_agent_addr: assert property (
    PECI_REQ |-> PECI_ADDR == 8'(`PAT_AGENT_BASE + r_q.agent))
    else $error("client address mismatch");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  c_result: cover property (upd);
  c_alert: cover property (alert_rise != 4'h0);
  c_two_pass: cover property (upd && r_q.two_pass);
  c_irq: cover property ($rose(IRQ));
endmodule : pat_top
`default_nettype wire

/* pkg/pat_cfg.svh */
// Purpose : constants of the agent temperature poller
// Assumes : included by the design modules
// Notes   : register offsets are word indices, byte address = 4 * index
`ifndef PAT_CFG_SVH
`define PAT_CFG_SVH
// ==========================================================
// register indices
`define PAT_IDX_AGENT_CFG 8'he0
`define PAT_IDX_TBASE1    8'he1
`define PAT_IDX_TBASE2    8'he2
`define PAT_IDX_TBASE3    8'he3
`define PAT_IDX_TBASE4    8'he4
`define PAT_IDX_DOM_HOST  8'he5
`define PAT_IDX_WARN      8'he8
`define PAT_IDX_SST       8'hf1
`define PAT_IDX_IRQ_STAT  8'hf8
`define PAT_IDX_IRQ_MASK  8'hf9
`define PAT_IDX_TEMP_HI   8'hfe
`define PAT_IDX_TEMP_LO   8'hff
`define PAT_IDX_HI        9
`define PAT_IDX_LO        2
// ==========================================================
// reset values and fields
`define PAT_TEMPERATURE_REFERENCE_VALUE_RST     7'h48
`define PAT_SST_RST       8'h48
`define PAT_DOM_HOST_MASK 8'hf3
`define PAT_BIT_EXT_HOST  0
`define PAT_BIT_RET_HIGH  1
`define PAT_AGENT_BASE    8'h30
`define PAT_ALERT_FAILS   2'h3
`define PAT_RESP_OKAY     2'h0
`define PAT_RESP_SLVERR   2'h2
// ==========================================================
// link bit rates
`define PAT_CLK_HZ        10000000
`define PAT_RATE0_HZ      1500000
`define PAT_RATE1_HZ      750000
`define PAT_RATE2_HZ      375000
`define PAT_RATE3_HZ      187500
`endif

/* pkg/pat_pkg.sv */
// Purpose : types of the agent temperature poller
// Assumes : pat_cfg.svh holds every number
// Notes   : one packed struct per module holds all state
`default_nettype none
package pat_pkg;
  typedef logic [7:0]  pat_byte_type;
  typedef logic [15:0] pat_temp_type;
  typedef enum logic [2:0] {
    PAT_IDLE = 3'b001,
    PAT_REQ  = 3'b010,
    PAT_GAP  = 3'b100
  } pat_poll_type;
  typedef struct packed {
    pat_poll_type    state;
    logic [1:0]      agent;
    logic            two_pass;
    logic            second;
    logic            req;
    logic            domain;
    pat_byte_type    addr;
    pat_temp_type    d0;
    pat_temp_type    temp;
    pat_byte_type    agent_cfg;
    logic [3:0][6:0] temperature_reference_value;
    pat_byte_type    dom_host;
    logic [1:0]      speed;
    logic [3:0]      absent;
    logic [3:0][1:0] fails;
    pat_byte_type    sst;
    logic [4:0]      irq_stat;
    logic [4:0]      irq_mask;
    logic            irq;
    logic            aw_full;
    logic            aw_ok;
    pat_byte_type    aw_idx;
    logic            w_full;
    logic            w_be;
    pat_byte_type    w_data;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    pat_byte_type    rdata;
    logic [1:0]      rresp;
  } pat_core_type;
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } pat_rate_type;
endpackage : pat_pkg
`default_nettype wire

/* rtl/pat_rate_gen.sv */
// Purpose : bit-rate enable pulse for the link engine
// Assumes : clock at PAT_CLK_HZ
// Notes   : periods round down to whole cycles
`timescale 1ns/100ps
`default_nettype none
`include "pat_cfg.svh"
module pat_rate_gen (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] speed,
  output var  logic       tick
);
  import pat_pkg::*;
  // ========================================================
  // period per speed code
  localparam logic [5:0] P0 = 6'(`PAT_CLK_HZ / `PAT_RATE0_HZ);
  localparam logic [5:0] P1 = 6'(`PAT_CLK_HZ / `PAT_RATE1_HZ);
  localparam logic [5:0] P2 = 6'(`PAT_CLK_HZ / `PAT_RATE2_HZ);
  localparam logic [5:0] P3 = 6'(`PAT_CLK_HZ / `PAT_RATE3_HZ);
  pat_rate_type r_q;
  pat_rate_type r_d;
  logic [5:0]   period;
  always_comb begin
    unique case (speed)
      2'h0:    period = P0;
      2'h1:    period = P1;
      2'h2:    period = P2;
      default: period = P3;
    endcase
    r_d = r_q;
    r_d.tick = 1'b0;
    // >= so a slower-to-faster change never overruns
    if (r_q.cnt >= 6'(period - 6'h1)) begin
      r_d.cnt  = 6'h0;
      r_d.tick = 1'b1;
    end else begin
      r_d.cnt = 6'(r_q.cnt + 6'h1);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign tick = r_q.tick;
  // ========================================================
  // checks
  a_tick_gap: assert property (@(posedge clk) disable iff (!resetn)
    tick |=> !tick [*4]) else $error("bit ticks too close");
  c_slow_tick: cover property (@(posedge clk) disable iff (!resetn)
    tick && speed == 2'h3);
endmodule : pat_rate_gen
`default_nettype wire

/* dv/pat_agent_model.sv */
// Purpose : behavioural processor agents answering link requests
// Assumes : agent index is address minus 30h, same clock as the poller
// Notes   : lines not qualified by done toggle, so stale data never matches
`timescale 1ns/100ps
`default_nettype none
module pat_agent_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        req,
  input  wire logic [7:0]  addr,
  input  wire logic        domain,
  input  wire logic [3:0]  fail,
  input  wire logic [5:0]  delay,
  output var  logic        done,
  output var  logic        ack,
  output var  logic [15:0] data
);
  // ==========================================================
  // answer after delay cycles; a failing agent gives no good check
  logic [5:0] cnt_q;
  logic [1:0] ag;
  assign ag = 2'(addr - 8'h30);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 6'h0;
      done  <= 1'b0;
      ack   <= 1'b0;
      data  <= 16'h0;
    end else if (req && !done && cnt_q >= delay) begin
      cnt_q <= 6'h0;
      done  <= 1'b1;
      ack   <= !fail[ag];
      data  <= domain ? 16'hff80 - 16'(ag) : 16'h0100 + 16'(ag);
    end else begin
      cnt_q <= (req && !done) ? cnt_q + 6'h1 : 6'h0;
      done  <= 1'b0;
      ack   <= !ack;
      data  <= ~data;
    end
  end
endmodule : pat_agent_model
`default_nettype wire

/* dv/tb.sv */
// Purpose : self-checking bench of the agent temperature poller
// Assumes : registers answer over AXI4-Lite, agents modelled behaviourally
// Notes   : wstrb 1 but for one lane-less write, lane 0 carries every register
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pat_pkg::*;
  logic        clk, resetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr;
  logic        rv, req, dom, tick, hob, irq, done, ack;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  br, rr, rs;
  logic [3:0]  fail, ws;
  logic [5:0]  dly;
  logic [7:0]  padr, la, v;
  logic [15:0] pdat;
  int          num_errors, total_checks, cyc, dn, k, p;
  int          per [4] = '{6, 13, 26, 53};
  // ==========================================================
  // rows: index, reset value, written value, read back
  logic [31:0] rows [10] = '{32'he0000f0f, 32'he148ff7f, 32'he4488505,
    32'he500fff3, 32'he800ff03, 32'hf148a5a5, 32'hfe00ff00, 32'hff00ff00,
    32'hf9001f1f, 32'hf800ff00};
  // poll rows: domain reg, agent cfg, result, client address
  logic [39:0] prow [5] = '{40'h1210010030, 40'h1011ff8030,
    40'h0011010030, 40'h0080010333, 40'h0040010232};
  pat_top pat_top_inst (.CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .PECI_REQ(req), .PECI_ADDR(padr),
    .PECI_DOMAIN(dom), .PECI_BIT_TICK(tick), .PECI_DONE(done),
    .PECI_ACK(ack), .PECI_DATA(pdat), .HOST_OWNS_BUS(hob), .IRQ(irq));
  pat_agent_model pat_agent_model_inst (.clk(clk), .resetn(resetn),
    .req(req), .addr(padr), .domain(dom), .fail(fail), .delay(dly),
    .done(done), .ack(ack), .data(pdat));
  // ==========================================================
  // clock, cycle count, link monitor
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req && done) begin
      dn <= dn + 1;
      la <= padr;
    end
  end
  initial begin
    wait (cyc == 30000);
    num_errors++;
    complete_run();
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, d, input logic [1:0] er);
    logic a, w, b, pa, pw;
    logic [1:0] r;
    a = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clk);
    awa <= {2'b0, i, 2'b0};
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    while (!b) begin
      @(negedge clk);
      pa = a & awr;
      pw = w & wrd;
      b = bv;
      r = br;
      @(posedge clk);
      if (pa) awv <= 1'b0;
      if (pa) a = 1'b0;
      if (pw) wv <= 1'b0;
      if (pw) w = 1'b0;
    end
    // late bready, so the response has to stand while it waits
    bry <= 1'b1;
    @(posedge clk);
    bry <= 1'b0;
    chk("write response", 16'(r), 16'(er));
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [7:0] d,
                    output logic [1:0] r);
    logic a, b, pa;
    a = 1'b1;
    b = 1'b0;
    @(posedge clk);
    ara <= {2'b0, i, 2'b0};
    arv <= 1'b1;
    rry <= 1'b1;
    while (!b) begin
      @(negedge clk);
      pa = a & arr;
      b = rv;
      d = rdat[7:0];
      r = rr;
      @(posedge clk);
      if (pa) arv <= 1'b0;
      if (pa) a = 1'b0;
      if (b) rry <= 1'b0;
    end
  endtask : rd
  task automatic rdc(input logic [7:0] i, exp);
    logic [1:0] r;
    rd(i, v, r);
    chk("register read", {6'h0, r, v}, {8'h0, exp});
  endtask : rdc
  task automatic wdone(input int n);
    int t;
    t = dn + n;
    while (dn < t) @(negedge clk);
  endtask : wdone
  task automatic tickp(output int q);
    while (tick !== 1'b1) @(negedge clk);
    @(negedge clk);
    q = 1;
    while (tick !== 1'b1) begin
      @(negedge clk);
      q++;
    end
  endtask : tickp
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ==========================================================
  // main sequence
  initial begin
    {resetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    fail = 4'h0;
    ws = 4'h1;
    dly = 6'd0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[n]) begin
      rdc(rows[n][31:24], rows[n][23:16]);
      wr(rows[n][31:24], rows[n][15:8], 2'h0);
      rdc(rows[n][31:24], rows[n][7:0]);
    end
    wr(8'h10, 8'h55, 2'h2);
    rd(8'h10, v, rs);
    chk("unmapped read", {6'h0, rs, v}, 16'h0200);
    chk("unmapped resp", 16'(rr), 16'h0002);
    // no byte lane enabled: answered, nothing stored
    ws <= 4'h0;
    wr(8'hf1, 8'h11, 2'h0);
    ws <= 4'h1;
    rdc(8'hf1, 8'ha5);
    for (int s = 0; s < 4; s++) begin
      wr(8'he8, 8'(s), 2'h0);
      tickp(p);
      tickp(p);
      chk("tick period", 16'(p), 16'(per[s]));
    end
    wr(8'he8, 8'h00, 2'h0);
    foreach (prow[n]) begin
      dly <= n[0] ? 6'd7 : 6'd0;
      wr(8'he5, prow[n][39:32], 2'h0);
      wr(8'he0, prow[n][31:24], 2'h0);
      wdone(3);
      wr(8'he0, 8'h00, 2'h0);
      while (req !== 1'b0) @(negedge clk);
      rdc(8'hfe, prow[n][23:16]);
      rdc(8'hff, prow[n][15:8]);
      chk("client address", 16'(la), 16'(prow[n][7:0]));
    end
    // mask 1f from the rows, result bit has been raised by polling
    repeat (2) @(negedge clk);
    chk("irq raised", 16'(irq), 16'h1);
    wr(8'hf9, 8'h00, 2'h0);
    repeat (2) @(negedge clk);
    chk("irq masked", 16'(irq), 16'h0);
    wr(8'hf9, 8'h10, 2'h0);
    repeat (2) @(negedge clk);
    chk("irq unmasked", 16'(irq), 16'h1);
    wr(8'hf8, 8'hff, 2'h0);
    repeat (2) @(negedge clk);
    chk("irq cleared", 16'(irq), 16'h0);
    // slow agent so a read fits between two failures
    fail <= 4'h2;
    dly <= 6'd30;
    wr(8'he0, 8'h20, 2'h0);
    wdone(2);
    rdc(8'he8, 8'h00);
    wdone(1);
    repeat (2) @(negedge clk);
    rdc(8'he8, 8'h20);
    fail <= 4'h0;
    wdone(1);
    repeat (2) @(negedge clk);
    rdc(8'he8, 8'h00);
    wr(8'he5, 8'h01, 2'h0);
    repeat (40) @(negedge clk);
    k = dn;
    repeat (50) @(negedge clk);
    chk("host owns bus", 16'(hob), 16'h0);
    chk("requests while external", 16'(dn - k), 16'h0);
    wr(8'he5, 8'h00, 2'h0);
    wdone(1);
    chk("host back", 16'(hob), 16'h1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdc(8'hf1, 8'h48);
    rdc(8'he0, 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
